//--- design/uox_execute.sv
// Execute unit for the upper opcodes, octal 31 through 72, of the instruction repertoire
`timescale 1ns/10ps
`default_nettype none
module uox_execute
   import uox_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Instruction from the sequencer
   input  wire logic              start,
   input  wire logic [WORD_W-1:0] instr,
   input  wire logic [ADDR_W-1:0] pc,
   input  wire logic              runReq,
   // Memory port
   output logic                   memRd,
   output logic                   memWr,
   output logic      [ADDR_W-1:0] memAddr,
   output logic      [WORD_W-1:0] memWrData,
   input  wire logic              memAck,
   input  wire logic [WORD_W-1:0] memRdData,
   // Console and external equipment
   input  wire logic              jumpSwitch,
   input  wire logic              stopSwitch,
   input  wire logic              inputReq,
   input  wire logic              outputReq,
   input  wire logic              extInterrupt,
   output logic                   ioStrobe,
   output logic      [ADDR_W-1:0] ioChannel,
   output logic      [WORD_W-1:0] ioData,
   output logic                   extFuncFlag,
   // Architectural registers and results
   output logic      [WORD_W-1:0] acc,
   output logic      [WORD_W-1:0] qReg,
   output logic      [WORD_W-1:0] indexReg,
   output logic      [ADDR_W-1:0] nextPc,
   output logic                   done,
   output logic                   stopLamp,
   output logic                   holdFetched
);
   // ****************************************
   // Decode
   // ****************************************
   logic [OP_W-1:0]   op;
   logic [ADDR_W-1:0] opY;
   logic [WORD_W-1:0] yWide;
   logic [WORD_W-1:0] diff;
   logic [ADDR_W-1:0] seqPc;
   logic [ADDR_W-1:0] skipPc;
   logic [WORD_W-1:0] shA;
   logic [WORD_W-1:0] shQ;
   logic              shLeft;
   logic [1:0]        shSel;
   logic              isShift;

   assign op     = instr[OP_LSB +: OP_W];
   assign opY    = instr[ADDR_W-1:0];
   assign yWide  = {{(WORD_W-ADDR_W){1'b0}}, opY};
   assign diff   = indexReg - yWide;
   assign seqPc  = pc + 9'h001;
   assign skipPc = pc + 9'h002;

   // Shift target from the low two opcode bits, direction from bit two
   assign shLeft  = op[2];
   assign shSel   = op[1:0];
   assign isShift = (op >= OP_SHR_Q && op <= OP_SHR_PAIR) ||
                    (op >= OP_SHL_Q && op <= OP_SHL_PAIR);

   uox_shifter #(.W(WORD_W)) shifter (
      .accIn (acc),
      .qIn   (qReg),
      .count (opY[CNT_W-1:0]),
      .left  (shLeft),
      .sel   (shSel),
      .accOut(shA),
      .qOut  (shQ)
   );

   // ****************************************
   // Execute state
   // ****************************************
   uox_state_t        state;
   uox_state_t        next_state;
   logic [WORD_W-1:0] next_acc;
   logic [WORD_W-1:0] next_qReg;
   logic [WORD_W-1:0] next_indexReg;
   logic [ADDR_W-1:0] next_nextPc;
   logic              next_done;
   logic              next_stopLamp;
   logic              next_holdFetched;
   logic              next_ioStrobe;
   logic [ADDR_W-1:0] next_ioChannel;
   logic [WORD_W-1:0] next_ioData;
   logic              next_extFuncFlag;
   logic [WORD_W-1:0] next_memWrData;

   // Single-cycle ops finish on start; return jump takes a memory read-modify-write
   always_comb begin
      next_state       = state;
      next_acc         = acc;
      next_qReg        = qReg;
      next_indexReg    = indexReg;
      next_nextPc      = nextPc;
      next_done        = 1'b0;
      next_stopLamp    = stopLamp;
      next_holdFetched = holdFetched;
      next_ioStrobe    = 1'b0;
      next_ioChannel   = ioChannel;
      next_ioData      = ioData;
      next_extFuncFlag = extFuncFlag;
      next_memWrData   = memWrData;
      // Resuming high-speed run releases the held instruction for execution
      if (runReq && stopLamp) begin
         next_stopLamp    = 1'b0;
         next_holdFetched = 1'b0;
      end
      case (state)
         UOX_IDLE: begin
            if (start) begin
               next_done   = 1'b1;
               next_nextPc = seqPc;
               if (isShift) begin
                  next_acc  = shA;
                  next_qReg = shQ;
               end
               case (op)
                  OP_INDEX_INC: begin
                     if (indexReg == yWide) next_nextPc = skipPc;
                     next_indexReg = indexReg + 15'h0001;
                  end
                  OP_INDEX_DEC: begin
                     if (diff == '0) next_nextPc = skipPc;
                     else next_indexReg = diff;
                  end
                  OP_RETURN_JMP: begin
                     next_done  = 1'b0;
                     next_state = UOX_READ;
                  end
                  OP_CHAN_OUT: begin
                     next_ioStrobe    = 1'b1;
                     next_ioChannel   = opY;
                     next_ioData      = qReg;
                     next_extFuncFlag = 1'b0;
                  end
                  OP_EXT_FUNC: begin
                     next_ioStrobe    = 1'b1;
                     next_ioChannel   = opY;
                     next_ioData      = {{(WORD_W-EXF_W){1'b0}}, qReg[EXF_W-1:0]};
                     next_extFuncFlag = 1'b1;
                  end
                  OP_CPL_ACC: next_acc  = ~acc;
                  OP_CPL_Q:   next_qReg = ~qReg;
                  OP_SW_JUMP: if (jumpSwitch) next_nextPc = opY;
                  OP_HALT_JUMP: begin
                     next_nextPc      = opY;
                     next_stopLamp    = 1'b1;
                     next_holdFetched = 1'b1;
                  end
                  OP_SW_HALT: begin
                     next_nextPc = opY;
                     if (stopSwitch) begin
                        next_stopLamp    = 1'b1;
                        next_holdFetched = 1'b1;
                     end
                  end
                  // Request levels are sampled on the start edge only
                  OP_IN_REQ_JMP:  if (!inputReq) next_nextPc = opY;
                  OP_OUT_REQ_JMP: if (!outputReq) next_nextPc = opY;
                  OP_INT_JMP:     if (!extInterrupt) next_nextPc = opY;
                  OP_IDLE: next_nextPc = seqPc;
                  default: next_nextPc = seqPc;
               endcase
            end
         end
         UOX_READ: begin
            if (memAck) begin
               // Keep the upper six bits, replace the address field
               next_memWrData = {memRdData[WORD_W-1:ADDR_W], seqPc};
               next_state     = UOX_WRITE;
            end
         end
         UOX_WRITE: begin
            if (memAck) begin
               next_nextPc = opY + 9'h001;
               next_done   = 1'b1;
               next_state  = UOX_IDLE;
            end
         end
         default: next_state = UOX_IDLE;
      endcase
   end

   // Memory strobes held until acknowledged; address is always Y
   assign memRd   = (state == UOX_READ);
   assign memWr   = (state == UOX_WRITE);
   assign memAddr = opY;

   // Register update
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state       <= UOX_IDLE;
         acc         <= '0;
         qReg        <= '0;
         indexReg    <= '0;
         nextPc      <= '0;
         done        <= 1'b0;
         stopLamp    <= 1'b0;
         holdFetched <= 1'b0;
         ioStrobe    <= 1'b0;
         ioChannel   <= '0;
         ioData      <= '0;
         extFuncFlag <= 1'b0;
         memWrData   <= '0;
      end else begin
         state       <= next_state;
         acc         <= next_acc;
         qReg        <= next_qReg;
         indexReg    <= next_indexReg;
         nextPc      <= next_nextPc;
         done        <= next_done;
         stopLamp    <= next_stopLamp;
         holdFetched <= next_holdFetched;
         ioStrobe    <= next_ioStrobe;
         ioChannel   <= next_ioChannel;
         ioData      <= next_ioData;
         extFuncFlag <= next_extFuncFlag;
         memWrData   <= next_memWrData;
      end
   end
endmodule
`default_nettype wire

//--- design/uox_pkg.sv
// Package of opcodes, field positions and widths for the upper opcode execute unit
package uox_pkg;
   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_W  = 15;
   localparam int ADDR_W  = 9;
   localparam int OP_W    = 6;
   localparam int OP_LSB  = 9;
   localparam int CNT_W   = 4;
   localparam int EXF_W   = 6;
   // ****************************************
   // Opcodes (octal)
   // ****************************************
   localparam logic [5:0] OP_INDEX_DEC  = 6'h19; // 31
   localparam logic [5:0] OP_INDEX_INC  = 6'h1b; // 33
   localparam logic [5:0] OP_RETURN_JMP = 6'h1e; // 36
   localparam logic [5:0] OP_SHR_Q      = 6'h20; // 40
   localparam logic [5:0] OP_SHR_ACC    = 6'h21; // 41
   localparam logic [5:0] OP_SHR_PAIR   = 6'h22; // 42
   localparam logic [5:0] OP_SHL_Q      = 6'h24; // 44
   localparam logic [5:0] OP_SHL_ACC    = 6'h25; // 45
   localparam logic [5:0] OP_SHL_PAIR   = 6'h26; // 46
   localparam logic [5:0] OP_CHAN_OUT   = 6'h29; // 51
   localparam logic [5:0] OP_IDLE       = 6'h2a; // 52
   localparam logic [5:0] OP_EXT_FUNC   = 6'h2b; // 53
   localparam logic [5:0] OP_CPL_Q      = 6'h2d; // 55
   localparam logic [5:0] OP_CPL_ACC    = 6'h2f; // 57
   localparam logic [5:0] OP_SW_JUMP    = 6'h35; // 65
   localparam logic [5:0] OP_HALT_JUMP  = 6'h36; // 66
   localparam logic [5:0] OP_SW_HALT    = 6'h37; // 67
   localparam logic [5:0] OP_IN_REQ_JMP = 6'h38; // 70
   localparam logic [5:0] OP_OUT_REQ_JMP = 6'h39; // 71
   localparam logic [5:0] OP_INT_JMP    = 6'h3a; // 72
   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {UOX_IDLE, UOX_READ, UOX_WRITE} uox_state_t;
endpackage

//--- design/uox_shifter.sv
// Shifter for Q, A and the AQ pair, both directions
`timescale 1ns/10ps
`default_nettype none
module uox_shifter
   import uox_pkg::*;
#(
   parameter int W = WORD_W
) (
   // Operands
   input  wire logic [W-1:0]     accIn,
   input  wire logic [W-1:0]     qIn,
   input  wire logic [CNT_W-1:0] count,
   // Control: left, target select 0=Q 1=A 2=pair
   input  wire logic             left,
   input  wire logic [1:0]       sel,
   // Results
   output logic      [W-1:0]     accOut,
   output logic      [W-1:0]     qOut
);
   logic [2*W-1:0] pair;
   logic [2*W-1:0] shPair;
   logic [W-1:0]   shA;
   logic [W-1:0]   shQ;

   // Logical shifts; zero fill keeps the unit free of sign policy
   always_comb begin
      pair   = {accIn, qIn};
      shPair = left ? (pair << count) : (pair >> count);
      shA    = left ? (accIn << count) : (accIn >> count);
      shQ    = left ? (qIn << count) : (qIn >> count);
      accOut = accIn;
      qOut   = qIn;
      case (sel)
         2'h0: qOut = shQ;
         2'h1: accOut = shA;
         2'h2: begin
            accOut = shPair[2*W-1:W];
            qOut   = shPair[W-1:0];
         end
         default: begin
            accOut = accIn;
            qOut   = qIn;
         end
      endcase
   end
endmodule
`default_nettype wire

//--- tb/uox_execute_props.sv
// Port checker for the upper opcode execute unit
`timescale 1ns/10ps
`default_nettype none
module uox_execute_props
   import uox_pkg::*;
(
   // Clock, reset and request
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        start,
   input wire logic [14:0] instr,
   input wire logic [8:0]  pc,
   // Memory and console
   input wire logic        memRd,
   input wire logic        memWr,
   input wire logic [14:0] memWrData,
   input wire logic        jumpSwitch,
   input wire logic        inputReq,
   // Results
   input wire logic        ioStrobe,
   input wire logic [8:0]  ioChannel,
   input wire logic [14:0] ioData,
   input wire logic        extFuncFlag,
   input wire logic [14:0] acc,
   input wire logic [14:0] qReg,
   input wire logic [14:0] indexReg,
   input wire logic [8:0]  nextPc,
   input wire logic        done,
   input wire logic        stopLamp
);
   // ****************************************
   // Helpers
   // ****************************************
   // Start only counts while neither memory phase of a return jump runs
   logic       go;
   logic [5:0] op;
   logic [8:0] y;
   logic [8:0] pc1;
   logic [8:0] pc2;
   logic       idxEq;
   assign go    = start & ~memRd & ~memWr;
   assign op    = instr[14:9];
   assign y     = instr[8:0];
   assign pc1   = pc + 9'h001;
   assign pc2   = pc + 9'h002;
   assign idxEq = indexReg == {6'h00, y};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ****************************************
   // Properties
   // ****************************************
   a_done_timely: assert property (go && op != OP_RETURN_JMP |=> done)
      else $error("done missing one cycle after start");
   a_idle_next: assert property (go && op == OP_IDLE |=> nextPc == $past(pc1) && $stable(acc))
      else $error("idle instruction changed state");
   a_index_inc: assert property (go && op == OP_INDEX_INC |=>
      indexReg == $past(indexReg) + 15'h0001 && nextPc == $past(idxEq ? pc2 : pc1))
      else $error("index increment wrong");
   a_chan_out: assert property (go && op == OP_CHAN_OUT |=> ioStrobe && !extFuncFlag
      && ioData == $past(qReg) && ioChannel == $past(y))
      else $error("channel output wrong");
   a_ext_func: assert property (go && op == OP_EXT_FUNC |=> ioStrobe && extFuncFlag
      && ioData == {9'h000, $past(qReg[5:0])})
      else $error("external function wrong");
   a_cpl_acc: assert property (go && op == OP_CPL_ACC |=> acc == ~$past(acc))
      else $error("complement of A wrong");
   a_sw_jump: assert property (go && op == OP_SW_JUMP |=> nextPc == $past(jumpSwitch ? y : pc1))
      else $error("switch jump target wrong");
   a_in_jump: assert property (go && op == OP_IN_REQ_JMP |=> nextPc == $past(inputReq ? pc1 : y))
      else $error("input request jump target wrong");
   a_halt_lamp: assert property (go && op == OP_HALT_JUMP |=> stopLamp && nextPc == $past(y))
      else $error("halting jump did not stop");
   a_rj_word: assert property (memWr |-> memWrData[8:0] == pc1 ##[1:20] done)
      else $error("return address word wrong");
endmodule
bind uox_execute uox_execute_props chk (.*);
`default_nettype wire

//--- tb/uox_io_model.sv
// Model of the console switches and external request lines
`timescale 1ns/10ps
`default_nettype none
module uox_io_model (
   // Clock
   input wire logic clk,
   // Levels seen by the execute unit
   output logic     jumpSwitch,
   output logic     stopSwitch,
   output logic     inputReq,
   output logic     outputReq,
   output logic     extInterrupt
);
   // ****************************************
   // Line levels
   // ****************************************
   logic [4:0] lines = 5'h00;
   // Levels move only at an edge, so a sampling jump sees one steady value
   task setLines(input logic [4:0] v);
      @(posedge clk) lines <= v;
   endtask
   assign {jumpSwitch, stopSwitch, inputReq, outputReq, extInterrupt} = lines;
endmodule
`default_nettype wire

//--- tb/uox_execute_tb.sv
// Self-checking bench for the upper opcode execute unit
`timescale 1ns/10ps
`default_nettype none
module uox_execute_tb
   import uox_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   logic        clk, rst_b, start, runReq, memAck;
   logic [14:0] instr, memRdData, memWrData, ioData, acc, qReg, indexReg;
   logic [8:0]  pc, curPc, memAddr, ioChannel, nextPc, memSeenAddr;
   logic        memRd, memWr, ioStrobe, extFuncFlag, done, stopLamp, holdFetched;
   logic        jumpSwitch, stopSwitch, inputReq, outputReq, extInterrupt;
   int          bad_count, compares, cyc;
   uox_execute uut (.*);
   uox_io_model pm (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Memory answers a cycle late; between reads its data bus keeps toggling
   always @(posedge clk) begin
      memAck <= (memRd | memWr) & ~memAck;
      memRdData <= (memRd & ~memAck) ? 15'h6400 : ~memRdData;
      // Last address presented while a memory phase runs
      if (memRd | memWr) memSeenAddr <= memAddr;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         end_sim();
      end
   end
   // ****************************************
   // Helpers
   // ****************************************
   task chk(input logic [14:0] got, input logic [14:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Start taken at the second edge; result looked at once done shows
   task automatic issue(input logic [5:0] o, input logic [8:0] y);
      int n = 0;
      @(posedge clk);
      start <= 1'b1;
      instr <= {o, y};
      pc <= curPc;
      @(posedge clk);
      start <= 1'b0;
      do @(negedge clk); while (done !== 1'b1 && ++n < 20);
      // A missing done is a fault, never a silent pass
      if (done !== 1'b1) begin
         bad_count++;
         $display("FAIL %0t done missing", $time);
      end
   endtask
   task runPulse();
      @(posedge clk);
      runReq <= 1'b1;
      @(posedge clk);
      runReq <= 1'b0;
      @(negedge clk);
      chk(15'(stopLamp), 15'h0000);
      chk(15'(holdFetched), 15'h0000);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_index();
      curPc = 9'h040;
      issue(OP_INDEX_INC, 9'h000);
      chk(indexReg, 15'h0001);
      chk(15'(nextPc), 15'h0042);
      issue(OP_INDEX_INC, 9'h005);
      chk(indexReg, 15'h0002);
      chk(15'(nextPc), 15'h0041);
      issue(OP_INDEX_DEC, 9'h002);
      chk(indexReg, 15'h0002);
      chk(15'(nextPc), 15'h0042);
      issue(OP_INDEX_DEC, 9'h001);
      chk(indexReg, 15'h0001);
      chk(15'(nextPc), 15'h0041);
   endtask
   task t_shift();
      issue(OP_CPL_ACC, 9'h000);
      chk(acc, 15'h7fff);
      issue(OP_SHL_ACC, 9'h1f4);
      chk(acc, 15'h7ff0);
      issue(OP_SHR_ACC, 9'h008);
      chk(acc, 15'h007f);
      issue(OP_CPL_Q, 9'h000);
      issue(OP_SHR_Q, 9'h001);
      chk(qReg, 15'h3fff);
      issue(OP_SHL_PAIR, 9'h002);
      chk(acc ^ qReg, 15'h7e01);
      issue(OP_SHR_PAIR, 9'h003);
      chk(acc ^ qReg, 15'h5fc0);
   endtask
   task t_io();
      issue(OP_CHAN_OUT, 9'h155);
      chk({ioStrobe, extFuncFlag, 4'h0, ioChannel}, 15'h4155);
      chk(ioData, 15'h5fff);
      issue(OP_EXT_FUNC, 9'h0aa);
      chk({ioStrobe, extFuncFlag, 4'h0, ioChannel}, 15'h60aa);
      chk(ioData, 15'h003f);
      issue(OP_SHL_Q, 9'h00f);
      chk(qReg, 15'h0000);
   endtask
   task t_jumps();
      curPc = 9'h0c2;
      issue(OP_RETURN_JMP, 9'h1c0);
      chk(15'(nextPc), 15'h01c1);
      chk(memWrData, 15'h64c3);
      chk(15'(memSeenAddr), 15'h01c0);
      for (int i = 0; i < 2; i++) begin
         pm.setLines(i ? 5'h1f : 5'h00);
         issue(OP_SW_JUMP, 9'h123);
         chk(15'(nextPc), i ? 15'h0123 : 15'h00c3);
         for (int k = 0; k < 3; k++) begin
            issue(OP_IN_REQ_JMP + 6'(k), 9'h124);
            chk(15'(nextPc), i ? 15'h00c3 : 15'h0124);
         end
         issue(OP_SW_HALT, 9'h127);
         chk(15'(stopLamp), 15'(i));
         chk(15'(nextPc), 15'h0127);
         runPulse();
      end
   endtask
   task t_misc();
      issue(OP_HALT_JUMP, 9'h12a);
      chk({stopLamp, holdFetched, 4'h0, nextPc}, 15'h612a);
      runPulse();
      issue(OP_IDLE, 9'h1ff);
      chk(15'(nextPc), 15'h00c3);
      chk(acc, 15'h003f);
   endtask
   task end_sim();
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {start, runReq, instr, pc, curPc} = '0;
      bad_count = 0;
      compares = 0;
      cyc = 0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_index();
      t_shift();
      t_io();
      t_jumps();
      t_misc();
      end_sim();
   end
endmodule
`default_nettype wire
